// [rtl/dual_limit_bin_sorter.sv]
// dual-window limit checker with bin sorting, handler outputs, tone and apb registers
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/10ps
`include "sorter_defs.svh"
//
// Contract
// (RL1) Both pass gives bin 1, inner fail only bin 2, both fail bin 3.
// (RL2) Software enables inner and outer tests before readings for three-bin sorting.
// (RL3) Fail flags are sticky and are cleared before the next part is tested.
// (RL4) Fail flags clear by an explicit clear command or by automatic clear.
// (RL5) Inner low asserts #1,#5; inner high #2,#5; outer low adds #3, high #4.
// (RL6) Outputs assert, held or pulsed, at configured polarity only on a failing test.
// (RL7) Tone mode: inside inner window gives normal tone and inside indication.
// (RL8) Tone mode: between windows rough tone and "1" indication; outside outer no tone.
// (RL9) With auto clear a limit's flag clears on entering idle, else stays.
// (RL10) Test fails at or beyond a limit; status reads 0 pass, 1 fail.
// (RL11) Polarity is active high or low, default high; outputs disabled by default.
// (RL12) Pulse width programmable 1 ms to 99999.999 s, default 2 ms, pulse off.
// (RL13) Bin and outputs update once per reading after both comparisons are done.
module dual_limit_bin_sorter #(
  parameter int MS_CYCLES = `MS_CYCLES
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic reading_valid_i,
  input wire logic [31:0] reading_i,
  input wire logic meas_idle_i,
  output logic [4:0] dout_o,
  output logic tone_normal_o,
  output logic tone_rough_o,
  output logic ind_inside_o,
  output logic ind_one_o,
  output logic [1:0] bin_o,
  output logic irq_o
);
  generate
    if (MS_CYCLES < 2) begin : g_bad
      $error("dual_limit_bin_sorter: MS_CYCLES must be at least 2");
    end
  endgenerate

  // configuration and limits
  logic [`CTRL_W-1:0] ctrl_reg;
  logic [`PULSE_MS_W-1:0] pulse_ms_reg;
  logic signed [31:0] inner_hi_reg;
  logic signed [31:0] inner_lo_reg;
  logic signed [31:0] outer_hi_reg;
  logic signed [31:0] outer_lo_reg;

  // apb answer
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;

  // measurement path
  logic v1_reg;
  sorter_pkg::cmp_s cmp_reg;
  sorter_pkg::cmp_s cmp_next;
  logic fail_inner_reg;
  logic fail_outer_reg;
  logic fail_inner_next;
  logic fail_outer_next;
  sorter_pkg::bin_t bin_reg;
  logic [4:0] hit_reg;
  logic [4:0] dout_reg;
  logic tone_normal_reg;
  logic tone_rough_reg;
  logic ind_inside_reg;
  logic ind_one_reg;
  logic idle_q_reg;

  // interrupts
  logic [`IRQ_W-1:0] irq_stat_reg;
  logic [`IRQ_W-1:0] irq_stat_next;
  logic [`IRQ_W-1:0] irq_mask_reg;
  logic irq_reg;

  // control bits
  wire inner_en = ctrl_reg[`CTRL_INNER_EN];
  wire outer_en = ctrl_reg[`CTRL_OUTER_EN];
  wire auto_inner = ctrl_reg[`CTRL_AUTO_INNER];
  wire auto_outer = ctrl_reg[`CTRL_AUTO_OUTER];
  wire out_en = ctrl_reg[`CTRL_OUT_EN];
  wire low_sense = ctrl_reg[`CTRL_LOW_SENSE];
  wire pulse_en = ctrl_reg[`CTRL_PULSE_EN];
  wire tone_en = ctrl_reg[`CTRL_TONE_EN];

  // apb decode
  wire setup = psel_i && !penable_i;
  wire access = psel_i && penable_i && pready_reg;
  wire sel_ctrl = (paddr_i == `OFS_CTRL);
  wire sel_cmd = (paddr_i == `OFS_CMD);
  wire sel_status = (paddr_i == `OFS_STATUS);
  wire sel_pulse = (paddr_i == `OFS_PULSE_MS);
  wire sel_ihi = (paddr_i == `OFS_INNER_HI);
  wire sel_ilo = (paddr_i == `OFS_INNER_LO);
  wire sel_ohi = (paddr_i == `OFS_OUTER_HI);
  wire sel_olo = (paddr_i == `OFS_OUTER_LO);
  wire sel_istat = (paddr_i == `OFS_IRQ_STAT);
  wire sel_imask = (paddr_i == `OFS_IRQ_MASK);
  wire sel_any = sel_ctrl || sel_cmd || sel_status || sel_pulse || sel_ihi || sel_ilo || sel_ohi || sel_olo
    || sel_istat || sel_imask;
  wire wr = access && pwrite_i && sel_any;
  wire rd_istat = access && !pwrite_i && sel_istat;
  wire wr_ctrl = wr && sel_ctrl;
  wire wr_pulse = wr && sel_pulse;
  wire wr_ihi = wr && sel_ihi;
  wire wr_ilo = wr && sel_ilo;
  wire wr_ohi = wr && sel_ohi;
  wire wr_olo = wr && sel_olo;
  wire wr_imask = wr && sel_imask;

  // pulse timer status
  wire pulse_busy;
  wire pulse_done;

  wire [31:0] status_word = {26'h0000000, pulse_busy, bin_reg, 1'b0, fail_outer_reg, fail_inner_reg}; // [RL10]
  wire [31:0] rd_data =
    sel_ctrl ? {24'h000000, ctrl_reg} :
    sel_status ? status_word :
    sel_pulse ? {5'h00, pulse_ms_reg} :
    sel_ihi ? inner_hi_reg :
    sel_ilo ? inner_lo_reg :
    sel_ohi ? outer_hi_reg :
    sel_olo ? outer_lo_reg :
    sel_istat ? {28'h0000000, irq_stat_reg} :
    sel_imask ? {28'h0000000, irq_mask_reg} :
    32'h00000000;

  // the pulse width is clamped into the legal range rather than refused
  wire [`PULSE_MS_W-1:0] pulse_wr_raw = pwdata_i[`PULSE_MS_W-1:0];
  wire pulse_big = (pwdata_i[31:`PULSE_MS_W] != 5'h00) || (pulse_wr_raw > `PULSE_MS_MAX);
  wire [`PULSE_MS_W-1:0] pulse_wr =
    pulse_big ? `PULSE_MS_MAX :
    (pulse_wr_raw < `PULSE_MS_MIN) ? `PULSE_MS_MIN :
    pulse_wr_raw; // [RL12]

  // limit comparisons; a limit reached counts as failed, a disabled window always passes
  wire signed [31:0] rd_s = reading_i;
  assign cmp_next.ihi = inner_en && (rd_s >= inner_hi_reg); // [RL10]
  assign cmp_next.ilo = inner_en && (rd_s <= inner_lo_reg); // [RL10]
  assign cmp_next.ohi = outer_en && (rd_s >= outer_hi_reg); // [RL10]
  assign cmp_next.olo = outer_en && (rd_s <= outer_lo_reg); // [RL10]

  wire inner_f = cmp_reg.ihi || cmp_reg.ilo;
  wire outer_f = cmp_reg.ohi || cmp_reg.olo;
  // outer failing with inner passing cannot happen with nested windows; it still sorts as bin 3
  wire [1:0] bin_now = outer_f ? 2'h3 : (inner_f ? 2'h2 : 2'h1); // [RL1]
  wire [4:0] hit_now = {inner_f, cmp_reg.ohi, cmp_reg.olo, cmp_reg.ihi, cmp_reg.ilo}; // [RL5]

  // fail flags: a set in the same cycle as a clear wins
  wire idle_enter = meas_idle_i && !idle_q_reg;
  wire clr_inner = (wr && sel_cmd && pwdata_i[`CMD_CLR_INNER]) || (auto_inner && idle_enter); // [RL4] [RL9]
  wire clr_outer = (wr && sel_cmd && pwdata_i[`CMD_CLR_OUTER]) || (auto_outer && idle_enter); // [RL4] [RL9]
  wire set_inner = v1_reg && inner_f;
  wire set_outer = v1_reg && outer_f;
  assign fail_inner_next = set_inner || (fail_inner_reg && !clr_inner); // [RL3]
  assign fail_outer_next = set_outer || (fail_outer_reg && !clr_outer); // [RL3]

  // interrupt events; a read clears only the bits it returned, so a fresh event survives
  wire [`IRQ_W-1:0] irq_ev = {pulse_done, set_outer, set_inner, v1_reg};
  wire [`IRQ_W-1:0] irq_clr = rd_istat ? prdata_reg[`IRQ_W-1:0] : {`IRQ_W{1'b0}};
  assign irq_stat_next = irq_ev | (irq_stat_reg & ~irq_clr);

  // pulse starts on every reading that fails a test while pulsed outputs are enabled
  wire pulse_start = v1_reg && (|hit_now) && out_en && pulse_en; // [RL12]
  wire drive_on = out_en && (!pulse_en || pulse_busy); // [RL6] [RL11]

  pulse_timer #(
    .MS_CYCLES(MS_CYCLES),
    .MS_W(`PULSE_MS_W)
  ) u_pulse (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .start_i(pulse_start),
    .len_ms_i(pulse_ms_reg),
    .busy_o(pulse_busy),
    .done_o(pulse_done)
  );

  // apb slave: zero wait states, answer registered in the setup cycle
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= setup;
      if (setup) begin
        prdata_reg <= pwrite_i ? 32'h00000000 : rd_data;
        pslverr_reg <= !sel_any;
      end else if (access) begin
        pslverr_reg <= 1'b0;
      end
    end
  end

  // software registers, one short process each
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ctrl_reg <= `CTRL_RST; // [RL11] [RL12]
    end else if (wr_ctrl) begin
      ctrl_reg <= pwdata_i[`CTRL_W-1:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pulse_ms_reg <= `PULSE_MS_RST; // [RL12]
    end else if (wr_pulse) begin
      pulse_ms_reg <= pulse_wr;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      inner_hi_reg <= `INNER_HI_RST;
    end else if (wr_ihi) begin
      inner_hi_reg <= pwdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      inner_lo_reg <= `INNER_LO_RST;
    end else if (wr_ilo) begin
      inner_lo_reg <= pwdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      outer_hi_reg <= `OUTER_HI_RST;
    end else if (wr_ohi) begin
      outer_hi_reg <= pwdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      outer_lo_reg <= `OUTER_LO_RST;
    end else if (wr_olo) begin
      outer_lo_reg <= pwdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      irq_mask_reg <= {`IRQ_W{1'b0}};
    end else if (wr_imask) begin
      irq_mask_reg <= pwdata_i[`IRQ_W-1:0];
    end
  end

  // stage one: register both comparisons of a reading
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      v1_reg <= 1'b0;
      cmp_reg <= '0;
      idle_q_reg <= 1'b1; // an idle input at reset release is no fresh entry into idle
    end else begin
      v1_reg <= reading_valid_i;
      idle_q_reg <= meas_idle_i;
      if (reading_valid_i) begin
        cmp_reg <= cmp_next;
      end
    end
  end

  // stage two: one classification per completed reading
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      bin_reg <= 2'h1;
      hit_reg <= 5'h00;
      fail_inner_reg <= 1'b0;
      fail_outer_reg <= 1'b0;
    end else begin
      fail_inner_reg <= fail_inner_next;
      fail_outer_reg <= fail_outer_next;
      if (v1_reg) begin
        bin_reg <= bin_now; // [RL13]
        hit_reg <= hit_now; // [RL13]
      end
    end
  end

  // tone and indications hold until the next reading
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      tone_normal_reg <= 1'b0;
      tone_rough_reg <= 1'b0;
      ind_inside_reg <= 1'b0;
      ind_one_reg <= 1'b0;
    end else if (v1_reg) begin
      tone_normal_reg <= tone_en && !inner_f && !outer_f; // [RL7]
      ind_inside_reg <= tone_en && !inner_f && !outer_f; // [RL7]
      tone_rough_reg <= tone_en && inner_f && !outer_f; // [RL8]
      ind_one_reg <= tone_en && inner_f && !outer_f; // [RL8]
    end
  end

  // handler outputs, one flop per line; disabled lines rest at the inactive level
  genvar i;
  generate
    for (i = 0; i < 5; i++) begin : g_dout
      always_ff @(posedge mclk_i) begin
        if (rst_i) begin
          dout_reg[i] <= 1'b0;
        end else begin
          dout_reg[i] <= (hit_reg[i] && drive_on) ^ low_sense; // [RL6] [RL5]
        end
      end
    end
  endgenerate

  // interrupt status, mask and level output
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      irq_stat_reg <= {`IRQ_W{1'b0}};
      irq_reg <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq_reg <= |(irq_stat_next & irq_mask_reg);
    end
  end

  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign dout_o = dout_reg;
  assign tone_normal_o = tone_normal_reg;
  assign tone_rough_o = tone_rough_reg;
  assign ind_inside_o = ind_inside_reg;
  assign ind_one_o = ind_one_reg;
  assign bin_o = bin_reg;
  assign irq_o = irq_reg;
endmodule

// [rtl/pulse_timer.sv]
// millisecond pulse timer that times the asserted width of the digital outputs
`timescale 1ns/10ps
`include "sorter_defs.svh"
module pulse_timer #(
  parameter int MS_CYCLES = `MS_CYCLES,
  parameter int MS_W = `PULSE_MS_W
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [MS_W-1:0] len_ms_i,
  output logic busy_o,
  output logic done_o
);
  localparam int PW = (MS_CYCLES > 1) ? $clog2(MS_CYCLES) : 1;

  generate
    if (MS_CYCLES < 2 || MS_W < 1) begin : g_bad
      $error("pulse_timer: MS_CYCLES must be at least 2");
    end
  endgenerate

  sorter_pkg::pulse_state_e state_reg;
  logic [PW-1:0] pre_reg;
  logic [MS_W-1:0] ms_reg;
  logic done_reg;
  wire tick = (pre_reg == PW'(MS_CYCLES - 1));
  wire last = tick && (ms_reg <= MS_W'(1));

  // a new start restarts the count so the width follows the newest reading
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_reg <= sorter_pkg::P_IDLE;
      pre_reg <= '0;
      ms_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (start_i) begin
        state_reg <= sorter_pkg::P_RUN;
        pre_reg <= '0;
        ms_reg <= len_ms_i;
      end else begin
        unique case (state_reg)
          sorter_pkg::P_IDLE: begin
            pre_reg <= '0;
          end
          sorter_pkg::P_RUN: begin
            pre_reg <= tick ? '0 : pre_reg + PW'(1);
            if (tick) begin
              ms_reg <= ms_reg - MS_W'(1);
            end
            if (last) begin
              state_reg <= sorter_pkg::P_IDLE;
              done_reg <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  assign busy_o = (state_reg == sorter_pkg::P_RUN);
  assign done_o = done_reg;
endmodule

// [rtl/sorter_defs.svh]
// register offsets, field positions, reset values and timing counts of the bin sorter
`ifndef SORTER_DEFS_SVH
`define SORTER_DEFS_SVH

`define OFS_CTRL 12'h000
`define OFS_CMD 12'h004
`define OFS_STATUS 12'h008
`define OFS_PULSE_MS 12'h00C
`define OFS_INNER_HI 12'h010
`define OFS_INNER_LO 12'h014
`define OFS_OUTER_HI 12'h018
`define OFS_OUTER_LO 12'h01C
`define OFS_IRQ_STAT 12'h020
`define OFS_IRQ_MASK 12'h024

`define CTRL_INNER_EN 0
`define CTRL_OUTER_EN 1
`define CTRL_AUTO_INNER 2
`define CTRL_AUTO_OUTER 3
`define CTRL_OUT_EN 4
`define CTRL_LOW_SENSE 5
`define CTRL_PULSE_EN 6
`define CTRL_TONE_EN 7
`define CTRL_W 8
`define CTRL_RST 8'h0C

`define CMD_CLR_INNER 0
`define CMD_CLR_OUTER 1

`define IRQ_READING 0
`define IRQ_INNER_FAIL 1
`define IRQ_OUTER_FAIL 2
`define IRQ_PULSE_DONE 3
`define IRQ_W 4

`define INNER_HI_RST 32'h00000001
`define INNER_LO_RST 32'hFFFFFFFF
`define OUTER_HI_RST 32'h00000002
`define OUTER_LO_RST 32'hFFFFFFFE

`define PULSE_MS_W 27
`define PULSE_MS_RST 27'h0000002
`define PULSE_MS_MIN 27'h0000001
`define PULSE_MS_MAX 27'h5F5E0FF

`define CLK_PERIOD_NS 4
`define PULSE_UNIT_NS 1000000
`define MS_CYCLES ((`PULSE_UNIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [rtl/sorter_pkg.sv]
// types shared by the bin sorter and its pulse timer
package sorter_pkg;
  typedef struct packed {
    logic olo;
    logic ohi;
    logic ilo;
    logic ihi;
  } cmp_s;
  typedef logic [1:0] bin_t;
  typedef enum logic [0:0] {P_IDLE, P_RUN} pulse_state_e;
endpackage

// [tb/dual_limit_bin_sorter_bench.sv]
// self-checking bench for the dual limit bin sorter
`timescale 1ns/10ps
`include "sorter_defs.svh"
module dual_limit_bin_sorter_bench;
  localparam int MS = 4;
  localparam int IHI = 32'h65;
  localparam int ILO = 32'h63;
  localparam int OHI = 32'h69;
  localparam int OLO = 32'h5F;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic rv = 1'b0;
  logic [31:0] reading = 32'h0;
  logic idle = 1'b0;
  logic low_sense = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, tn, tr, ii, io, irq;
  logic [4:0] dout;
  logic [1:0] bin, seen;
  int err_count = 0;
  int compares = 0;
  logic [31:0] rd_tab [7] = '{32'h64, 32'h63, 32'h65, 32'h5F, 32'h69, 32'h67, 32'h6E};
  logic [11:0] ra [8] = '{`OFS_CTRL, `OFS_STATUS, `OFS_PULSE_MS, `OFS_INNER_HI, `OFS_INNER_LO,
    `OFS_OUTER_HI, `OFS_OUTER_LO, `OFS_IRQ_MASK};
  logic [31:0] rsv [8] = '{32'h0000000C, 32'h00000008, 32'h00000002, `INNER_HI_RST, `INNER_LO_RST,
    `OUTER_HI_RST, `OUTER_LO_RST, 32'h00000000};
  initial forever #2 mclk_i = ~mclk_i;
  dual_limit_bin_sorter #(.MS_CYCLES(MS)) dut (.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .reading_valid_i(rv), .reading_i(reading), .meas_idle_i(idle),
    .dout_o(dout), .tone_normal_o(tn), .tone_rough_o(tr), .ind_inside_o(ii), .ind_one_o(io), .bin_o(bin),
    .irq_o(irq));
  handler_model hm (.mclk_i(mclk_i), .rst_i(rst_i), .dout_i(dout), .low_sense_i(low_sense), .bin_o(seen));
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // request held until ready is sampled high; only the watchdog ends a stuck wait
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    @(posedge mclk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    do @(posedge mclk_i); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rdr(input logic [11:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask
  task automatic fire(input logic [31:0] v);
    @(posedge mclk_i);
    rv <= 1'b1;
    reading <= v;
    @(posedge mclk_i);
    rv <= 1'b0;
  endtask
  // bin two edges, lines three, handler four after the reading is taken
  task automatic meas(input logic [31:0] v);
    fire(v);
    repeat (5) @(posedge mclk_i);
  endtask
  function automatic logic [6:0] model(input logic [31:0] v);
    logic il, ih, ol, oh;
    il = $signed(v) <= ILO;
    ih = $signed(v) >= IHI;
    ol = $signed(v) <= OLO;
    oh = $signed(v) >= OHI;
    model = {(ol | oh) ? 2'h3 : ((il | ih) ? 2'h2 : 2'h1), il | ih, oh, ol, ih, il};
  endfunction
  task automatic t_reset;
    logic [31:0] r;
    logic e;
    chk("bin", 32'h1, bin);
    chk("dout", 32'h0, dout);
    foreach (ra[i]) begin
      rdr(ra[i], r);
      chk("reset value", rsv[i], r);
    end
    apb(1'b1, 12'h030, 32'hFFFFFFFF, r, e);
    chk("slverr", 32'h1, e);
    apb(1'b0, 12'h030, 32'h0, r, e);
    chk("unmapped", 32'h0, r);
  endtask
  task automatic t_bins;
    logic [31:0] r;
    logic [6:0] e;
    wr(`OFS_INNER_HI, IHI);
    wr(`OFS_INNER_LO, ILO);
    wr(`OFS_OUTER_HI, OHI);
    wr(`OFS_OUTER_LO, OLO);
    wr(`OFS_CTRL, 32'h00000093);
    foreach (rd_tab[i]) begin
      wr(`OFS_CMD, 32'h00000003);
      meas(rd_tab[i]);
      e = model(rd_tab[i]);
      chk("bin", e[6:5], bin);
      chk("dout", e[4:0], dout);
      chk("handler", e[6:5], seen);
      chk("tone_normal", e[6:5] == 2'h1, tn);
      chk("ind_inside", e[6:5] == 2'h1, ii);
      chk("tone_rough", e[6:5] == 2'h2, tr);
      chk("ind_one", e[6:5] == 2'h2, io);
      rdr(`OFS_STATUS, r);
      chk("status", {e[6:5], 1'b0, e[3] | e[2], e[4]}, r[4:0]);
    end
    meas(32'h63);
    meas(32'h64);
    rdr(`OFS_STATUS, r);
    chk("sticky", 32'h1, r[0]);
    wr(`OFS_CMD, 32'h00000001);
    rdr(`OFS_STATUS, r);
    chk("cleared", 32'h0, r[0]);
  endtask
  task automatic t_auto;
    logic [31:0] r;
    wr(`OFS_CMD, 32'h00000003);
    wr(`OFS_CTRL, 32'h00000097);
    meas(32'h6E);
    idle <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rdr(`OFS_STATUS, r);
    chk("auto clear", 32'h2, r[1:0]);
    idle <= 1'b0;
    wr(`OFS_CTRL, 32'h0000009B);
    meas(32'h6E);
    idle <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rdr(`OFS_STATUS, r);
    chk("auto clear outer", 32'h1, r[1:0]);
    idle <= 1'b0;
  endtask
  task automatic t_sense;
    wr(`OFS_CMD, 32'h00000003);
    low_sense <= 1'b1;
    wr(`OFS_CTRL, 32'h00000033);
    meas(32'h64);
    chk("dout low pass", 32'h1F, dout);
    meas(32'h63);
    chk("dout low fail", 32'h0E, dout);
    chk("handler", 32'h2, seen);
    wr(`OFS_CTRL, 32'h00000023);
    wr(`OFS_CMD, 32'h00000003);
    meas(32'h63);
    chk("dout disabled", 32'h1F, dout);
    low_sense <= 1'b0;
  endtask
  task automatic t_pulse;
    logic [31:0] r;
    int n;
    chk("irq masked", 32'h0, irq);
    wr(`OFS_PULSE_MS, 32'h0);
    rdr(`OFS_PULSE_MS, r);
    chk("pulse clamp", 32'h1, r);
    wr(`OFS_CMD, 32'h00000003);
    wr(`OFS_CTRL, 32'h00000053);
    fire(32'h63);
    n = 0;
    repeat (30) begin
      @(posedge mclk_i);
      if (dout === 5'h11) n++;
    end
    // one programmed ms lasts MS clock cycles, so the width is exact
    chk("pulse width", MS, n);
    chk("pulse end", 32'h0, dout);
    wr(`OFS_IRQ_MASK, 32'h00000008);
    repeat (2) @(posedge mclk_i);
    chk("irq", 32'h1, irq);
    rdr(`OFS_IRQ_STAT, r);
    chk("pulse done", 32'h1, r[3]);
    repeat (3) @(posedge mclk_i);
    chk("irq cleared", 32'h0, irq);
  endtask
  task end_of_test;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_reset;
    t_bins;
    t_auto;
    t_sense;
    t_pulse;
    end_of_test;
  end
  initial begin
    repeat (20000) @(posedge mclk_i);
    err_count++;
    end_of_test;
  end
endmodule

// [tb/handler_model.sv]
// component handler model that sorts parts from the digital output lines
`timescale 1ns/10ps
module handler_model (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [4:0] dout_i,
  input wire logic low_sense_i,
  output logic [1:0] bin_o
);
  logic [4:0] hit;
  assign hit = dout_i ^ {5{low_sense_i}};
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      bin_o <= 2'h1;
    end else begin
      bin_o <= (hit[2] | hit[3]) ? 2'h3 : (hit[4] ? 2'h2 : 2'h1);
    end
  end
endmodule

// [tb/sorter_properties.sv]
// port-level properties of the dual limit bin sorter
`timescale 1ns/10ps
module sorter_properties #(
  parameter int MS_CYCLES = 4
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic reading_valid_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [4:0] dout_o,
  input wire logic tone_normal_o,
  input wire logic tone_rough_o,
  input wire logic ind_inside_o,
  input wire logic ind_one_o,
  input wire logic [1:0] bin_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  AST_BIN_LEGAL: assert property (bin_o != 2'h0) else $error("bin code zero");
  AST_TONE_ONE: assert property (!(tone_normal_o && tone_rough_o)) else $error("two tones");
  AST_IND_TONE: assert property (ind_inside_o == tone_normal_o && ind_one_o == tone_rough_o)
    else $error("indication differs from tone");
  AST_NORMAL_BIN: assert property (tone_normal_o |-> bin_o == 2'h1) else $error("normal tone not bin 1");
  AST_ROUGH_BIN: assert property (tone_rough_o |-> bin_o == 2'h2) else $error("rough tone not bin 2");
  AST_COMMON_OUT: assert property (dout_o[4] == (dout_o[0] | dout_o[1]) || dout_o[4] == (dout_o[0] & dout_o[1]))
    else $error("common output disagrees with inner lines");
  // a one-edge reset also moves the bin, hence the reset escape
  AST_BIN_TIMED: assert property ($changed(bin_o) |-> $past(reading_valid_i, 2) || $past(rst_i))
    else $error("bin moved without a reading");
  AST_READY_AFTER_SETUP: assert property (psel_i && !penable_i |=> pready_o) else $error("no ready after setup");
  AST_READY_ONE: assert property (pready_o |=> !pready_o) else $error("ready longer than one cycle");
  AST_ERR_IN_ACCESS: assert property (pslverr_o |-> pready_o) else $error("error outside access");
endmodule
bind dual_limit_bin_sorter sorter_properties #(.MS_CYCLES(MS_CYCLES)) chk (.mclk_i(mclk_i), .rst_i(rst_i),
  .psel_i(psel_i), .penable_i(penable_i), .reading_valid_i(reading_valid_i), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .dout_o(dout_o), .tone_normal_o(tone_normal_o), .tone_rough_o(tone_rough_o),
  .ind_inside_o(ind_inside_o), .ind_one_o(ind_one_o), .bin_o(bin_o));
